// [dv/uhis_irq_status_checker.sv]
// Checker: port-level assertions for the interrupt status block
module uhis_irq_status_checker
  import uhis_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        REG_SEL,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic        TRANSFER_DESCRIPTOR_DONE,
  input wire logic        CLOCKS_STABLE,
  input wire logic        SUSPEND_ENTER,
  input wire logic        SUSPENDED,
  input wire logic        DMA_DONE,
  input wire logic        FRAME_START,
  input wire logic        IRQ,
  input wire logic        WAKE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Status read with no write beside it, so a clear cannot hide the flag
  wire rd_st = REG_SEL && REG_RD && !REG_WR && REG_ADDR == IRQ_EVENT_STATUS_OFS;
  wire acc   = REG_SEL && (REG_RD || REG_WR);
  wire ev    = DMA_DONE || FRAME_START || TRANSFER_DESCRIPTOR_DONE || SUSPEND_ENTER;
  td_flag_a: assert property (TRANSFER_DESCRIPTOR_DONE ##1 rd_st |=> REG_RDATA[7]) else $error("td flag");
  clk_flag_a: assert property ($rose(CLOCKS_STABLE) ##1 rd_st |=> REG_RDATA[6]) else $error("clk flag");
  susp_flag_a: assert property (SUSPEND_ENTER ##1 rd_st |=> REG_RDATA[5]) else $error("susp flag");
  dma_flag_a: assert property (DMA_DONE ##1 rd_st |=> REG_RDATA[3]) else $error("dma flag");
  sof_flag_a: assert property (FRAME_START ##1 rd_st |=> REG_RDATA[1]) else $error("sof flag");
  // Clearing every flag with no new event must drop the line at once
  clear_drop_a: assert property (REG_SEL && REG_WR && REG_ADDR == IRQ_EVENT_STATUS_OFS
    && REG_WDATA[7:0] == 8'hEA && !ev && !$rose(CLOCKS_STABLE) |=> !IRQ) else $error("irq after clear");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(ev || CLOCKS_STABLE || REG_SEL && REG_WR))
    else $error("irq without cause");
  wake_on_a: assert property (SUSPENDED && acc |=> WAKE) else $error("no wake");
  rdata_hold_a: assert property (!(REG_SEL && REG_RD) |=> $stable(REG_RDATA)) else $error("rdata moved");
endmodule : uhis_irq_status_checker

// [dv/uhis_irq_status_tb.sv]
// Testbench: drives the status block through its register port and event inputs
module uhis_irq_status_tb
  import uhis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RSV = 32'h5;
  logic        CLK = 1'b0, RST_N = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0, susp = 1'b0, irq, wake;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [7:0]  ev = 8'h0; // Event pulses placed at their flag positions
  logic        gie = 1'b0; // Global enable, toggled to show it has no say
  int          n_errors = 0, tests_run = 0, cyc = 0;
  always #12.5 CLK = ~CLK;
  // Short settle count keeps the reserved-bit check quick
  uhis_irq_status #(.SETTLE_CYC(8)) uhis_irq_status_i (.CLK(CLK), .RST_N(RST_N), .REG_SEL(sel),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .TRANSFER_DESCRIPTOR_DONE(ev[7]), .CLOCKS_STABLE(ev[6]), .SUSPEND_ENTER(ev[5]), .SUSPENDED(susp),
    .DMA_DONE(ev[3]), .FRAME_START(ev[1]), .GLOBAL_IRQ_ENABLE(gie), .IRQ(irq), .WAKE(wake));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] act);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask : chk
  // Line is judged a cycle later, so registered or direct both settle
  task automatic chk_irq(logic exp);
    @(negedge CLK);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : chk_irq
  // One-cycle strobe; read data is taken after the strobe edge
  task automatic acc(logic w, logic [15:0] a, logic [31:0] d = 32'h0);
    @(negedge CLK);
    {sel, wr, rd, addr, wdata} = {1'b1, w, !w, a, d};
    @(negedge CLK);
    {sel, wr, rd} = 3'h0;
    got = rdata;
  endtask : acc
  task automatic pulse(logic [7:0] e);
    @(negedge CLK);
    ev = e;
    @(negedge CLK);
    ev = 8'h0;
  endtask : pulse
  // Event pulse with a status read in the very next cycle
  task automatic pulse_rd(logic [7:0] e);
    @(negedge CLK);
    ev = e;
    @(negedge CLK);
    ev = 8'h0;
    {sel, rd, addr} = {1'b1, 1'b1, IRQ_EVENT_STATUS_OFS};
    @(negedge CLK);
    {sel, rd} = 2'h0;
    got = rdata;
  endtask : pulse_rd
  task automatic t_reset();
    acc(0, IRQ_EVENT_STATUS_OFS);
    chk("status at reset", 32'h0, got);
    acc(0, WAKE_HOLD_OFS);
    chk("hold at reset", {WAKE_RESET, 16'h0000}, got);
    repeat (10) @(negedge CLK);
    acc(0, IRQ_EVENT_STATUS_OFS);
    chk("reserved settled", RSV, got);
    acc(0, 16'h031C);
    chk("unmapped read", 32'h0, got);
    $display("t_reset done");
  endtask : t_reset
  // Every flag read right after its event, then zero write kept, one write cleared
  task automatic t_flags();
    int b[5] = '{7, 6, 5, 3, 1};
    foreach (b[i]) begin
      gie = (i % 2 == 1);
      pulse_rd(8'h1 << b[i]);
      chk("flag seen", RSV | (32'h1 << b[i]), got);
      acc(1, IRQ_EVENT_STATUS_OFS, 32'h0);
      acc(0, IRQ_EVENT_STATUS_OFS);
      chk("flag set", RSV | (32'h1 << b[i]), got);
      chk_irq(1'b0);
      acc(1, IRQ_EVENT_STATUS_OFS, 32'h1 << b[i]);
      acc(0, IRQ_EVENT_STATUS_OFS);
      chk("flag cleared", RSV, got);
    end
    $display("t_flags done");
  endtask : t_flags
  task automatic t_irq();
    acc(1, IRQ_EVENT_STATUS_OFS, 32'hEA);
    acc(1, IRQ_ENABLE_OFS, 32'h0A);
    acc(0, IRQ_ENABLE_OFS);
    chk("enable value", 32'h0000_000A, got);
    pulse(8'h08);
    pulse(8'h02);
    pulse(8'h80);
    chk_irq(1'b1);
    acc(1, IRQ_EVENT_STATUS_OFS, 32'h08);
    chk_irq(1'b1);
    acc(1, IRQ_EVENT_STATUS_OFS, 32'h02);
    chk_irq(1'b0);
    acc(1, IRQ_ENABLE_OFS, 32'h80);
    chk_irq(1'b1);
    acc(1, IRQ_EVENT_STATUS_OFS, 32'hEA);
    chk_irq(1'b0);
    acc(1, IRQ_ENABLE_OFS, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_wake();
    int n = 0;
    acc(1, WAKE_HOLD_OFS, 32'h0005_0000);
    acc(0, WAKE_HOLD_OFS);
    chk("hold value", 32'h0005_0000, got);
    susp = 1'b1;
    acc(0, IRQ_EVENT_STATUS_OFS);
    repeat (20) begin
      n += (wake === 1'b1);
      @(negedge CLK);
    end
    chk("wake cycles", 32'd5, n);
    susp = 1'b0;
    $display("t_wake done");
  endtask : t_wake
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Ceiling well above the roughly 150 cycles the tests need
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("CHECK FAILED timeout expected 0 seen %0d", cyc);
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge CLK);
    RST_N = 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_wake();
    tally_and_finish();
  end
endmodule : uhis_irq_status_tb
bind uhis_irq_status uhis_irq_status_checker uhis_irq_status_checker_i (.CLK, .RST_N, .REG_SEL, .REG_WR, .REG_RD,
  .REG_ADDR, .REG_WDATA, .REG_RDATA, .TRANSFER_DESCRIPTOR_DONE, .CLOCKS_STABLE, .SUSPEND_ENTER, .SUSPENDED,
  .DMA_DONE, .FRAME_START, .IRQ, .WAKE);

// [pkg/uhis_pkg.sv]
// Package: offsets, field positions, reset values and timing counts of the interrupt status block
package uhis_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] IRQ_EVENT_STATUS_OFS = 16'h0310;
  localparam logic [15:0] IRQ_ENABLE_OFS       = 16'h0314;
  localparam logic [15:0] WAKE_HOLD_OFS        = 16'h0318;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PERIODIC_BIT   = 7;
  localparam int CLK_STABLE_BIT = 6;
  localparam int SUSPEND_BIT    = 5;
  localparam int RSVD4_BIT      = 4;
  localparam int DMA_END_BIT    = 3;
  localparam int RSVD2_BIT      = 2;
  localparam int SOF_BIT        = 1;
  localparam int RSVD0_BIT      = 0;
  localparam int WAKE_LSB       = 16;
  localparam int WAKE_MSB       = 31;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  ENABLE_RESET   = 8'h00;
  localparam logic [15:0] WAKE_RESET     = 16'h0100;
  localparam logic [7:0]  FLAG_MASK      = 8'hEA;
  localparam logic [7:0]  RSVD_SET_MASK  = 8'h05;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int RSVD_SETTLE_NS   = 1000;
  localparam int RSVD_SETTLE_CYC  = (RSVD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : uhis_pkg

// [src/uhis_irq_status.sv]
// Interrupt status low byte of the host controller, with enable register and wake hold
// Function
// - Bit 7 sets when a periodic descriptor, or the masked descriptor set, completes.
// - Each flag drives the interrupt only while its enable bit is one.
// - Bit 6 sets when internal clocks run stably; zero otherwise.
// - Bit 5 sets when the controller enters suspend; zero otherwise.
// - Access while suspended wakes the device for the programmed hold count.
// - Bit 3 sets when a DMA transfer completes; zero otherwise.
// - Bit 1 sets on each start-of-frame event; zero otherwise.
// - Reserved bits 2 and 0 read zero after reset, then one shortly after.
// - Writing one clears a flag; writing zero leaves it.
// - Flags set on events whatever the global interrupt enable says.
module uhis_irq_status
  import uhis_pkg::*;
#(
  parameter int SETTLE_CYC = RSVD_SETTLE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        REG_SEL,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  input  wire logic        TRANSFER_DESCRIPTOR_DONE,
  input  wire logic        CLOCKS_STABLE,
  input  wire logic        SUSPEND_ENTER,
  input  wire logic        SUSPENDED,
  input  wire logic        DMA_DONE,
  input  wire logic        FRAME_START,
  input  wire logic        GLOBAL_IRQ_ENABLE,
  output logic             IRQ,
  output logic             WAKE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  enable_q;
  logic [7:0]  enable_d;
  logic [15:0] wake_hold_q;
  logic [15:0] wake_hold_d;
  logic        clk_stable_q;
  logic        clk_stable_d;
  logic [15:0] settle_q;
  logic [15:0] settle_d;
  logic        rsvd_up_q;
  logic        rsvd_up_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        irq_q;
  logic        irq_d;
  logic [7:0]  events;
  logic        wr_status;
  logic        wr_enable;
  logic        wr_wake;
  logic        access;
  logic        wake_awake;

  // Address decode of a strobe at one register
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign access    = REG_SEL & (REG_WR | REG_RD);
  assign wr_status = REG_SEL & REG_WR & hit(REG_ADDR, IRQ_EVENT_STATUS_OFS);
  assign wr_enable = REG_SEL & REG_WR & hit(REG_ADDR, IRQ_ENABLE_OFS);
  assign wr_wake   = REG_SEL & REG_WR & hit(REG_ADDR, WAKE_HOLD_OFS);

  // ----------------------------------------------------------------
  // Event vector; clock-stable is taken on its rising edge only
  // ----------------------------------------------------------------
  always_comb begin
    events                 = 8'h00;
    events[PERIODIC_BIT]   = TRANSFER_DESCRIPTOR_DONE;
    events[CLK_STABLE_BIT] = CLOCKS_STABLE & ~clk_stable_q;
    events[SUSPEND_BIT]    = SUSPEND_ENTER;
    events[DMA_END_BIT]    = DMA_DONE;
    events[SOF_BIT]        = FRAME_START;
  end

  // ----------------------------------------------------------------
  // Status next state; a set in the clear cycle wins
  // ----------------------------------------------------------------
  // Clear first, then OR in events, so a new event is never lost
  always_comb begin
    status_d     = status_q;
    clk_stable_d = CLOCKS_STABLE;
    if (wr_status) begin
      status_d = status_q & ~(REG_WDATA[7:0] & FLAG_MASK);
    end
    // Global enable is deliberately not consulted here
    status_d = status_d | (events & FLAG_MASK);
  end

  // Status flags and the clock-stable edge register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_q     <= STATUS_RESET;
      clk_stable_q <= 1'b0;
    end else begin
      status_q     <= status_d;
      clk_stable_q <= clk_stable_d;
    end
  end

  // ----------------------------------------------------------------
  // Enable and wake hold registers
  // ----------------------------------------------------------------
  // Reserved enable positions are masked so they always read zero
  always_comb begin
    enable_d    = enable_q;
    wake_hold_d = wake_hold_q;
    if (wr_enable) begin
      enable_d = REG_WDATA[7:0] & FLAG_MASK;
    end
    if (wr_wake) begin
      wake_hold_d = REG_WDATA[WAKE_MSB:WAKE_LSB];
    end
  end

  // Written only by the processor; no hardware source
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      enable_q    <= ENABLE_RESET;
      wake_hold_q <= WAKE_RESET;
    end else begin
      enable_q    <= enable_d;
      wake_hold_q <= wake_hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Reserved bits 2 and 0 rise after the settle interval
  // ----------------------------------------------------------------
  always_comb begin
    settle_d  = settle_q;
    rsvd_up_d = rsvd_up_q;
    if (!rsvd_up_q) begin
      if (settle_q >= 16'(SETTLE_CYC - 1)) begin
        rsvd_up_d = 1'b1;
      end else begin
        settle_d = settle_q + 16'h0001;
      end
    end
  end

  // Counter freezes once the reserved bits are up, so it cannot wrap
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      settle_q  <= 16'h0000;
      rsvd_up_q <= 1'b0;
    end else begin
      settle_q  <= settle_d;
      rsvd_up_q <= rsvd_up_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered so it holds until the next read
  // ----------------------------------------------------------------
  // Reads have no side effects, so polling never loses a flag
  always_comb begin
    rdata_d = rdata_q;
    if (REG_SEL && REG_RD) begin
      rdata_d = 32'h0000_0000;
      if (hit(REG_ADDR, IRQ_EVENT_STATUS_OFS)) begin
        rdata_d[7:0] = status_q | (rsvd_up_q ? RSVD_SET_MASK : 8'h00);
      end else if (hit(REG_ADDR, IRQ_ENABLE_OFS)) begin
        rdata_d[7:0] = enable_q;
      end else if (hit(REG_ADDR, WAKE_HOLD_OFS)) begin
        rdata_d[WAKE_MSB:WAKE_LSB] = wake_hold_q;
      end
    end
  end

  // Read data register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // Built from next flags and enables, so the line moves with them
  always_comb begin
    // Stays high while any enabled flag is still set
    irq_d = |(status_d & enable_d);
  end

  // Registered so the pin never glitches while flags change
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Wake hold: any access during suspend restarts the timer
  // ----------------------------------------------------------------
  uhis_wake_timer #(
    .WIDTH (16)
  ) uhis_wake_timer_i (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .start    (access & SUSPENDED),
    .duration (wake_hold_q),
    .awake    (wake_awake)
  );

  assign REG_RDATA = rdata_q;
  assign IRQ       = irq_q;
  assign WAKE      = wake_awake;

endmodule : uhis_irq_status

// [src/uhis_wake_timer.sv]
// Wake timer: holds the controller awake for a programmed count after an access in suspend
module uhis_wake_timer
  import uhis_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] duration,
  output logic                  awake
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // ----------------------------------------------------------------
  // Down counter, reloaded on every access in suspend so bursts keep it awake
  // ----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    if (start) begin
      count_d = duration;
    end else if (count_q != '0) begin
      count_d = count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign awake = (count_q != '0);

endmodule : uhis_wake_timer
